// ===== srw_pkg.sv
package srw_pkg;

    // Clock and nominal times
    localparam int CLK_PERIOD_NS    = 10;
    localparam int RELEASE_DELAY_NS = 200_000_000;
    localparam int RESTART_MIN_NS   = 140_000_000;
    localparam int WD_TIMEOUT_NS    = 1_560_000_000;

    // Least times round up, longest times round down
    localparam int RELEASE_CYCLES =
        (RELEASE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESTART_MIN_CYCLES =
        (RESTART_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WD_TIMEOUT_CYCLES = WD_TIMEOUT_NS / CLK_PERIOD_NS;

    localparam int CNT_W = 28;

    // Synchroniser lanes
    localparam int NUM_SYNC = 5;
    localparam int SY_SUP   = 0;
    localparam int SY_MR    = 1;
    localparam int SY_KICK  = 2;
    localparam int SY_LL    = 3;
    localparam int SY_PF    = 4;

    // Values after reset
    localparam logic [NUM_SYNC-1:0] RST_SYNC = 5'h00;
    localparam logic [CNT_W-1:0]    RST_CNT  = 28'h0000000;

    typedef enum logic [1:0] {
        ST_HOLD  = 2'b00,
        ST_DELAY = 2'b01,
        ST_RUN   = 2'b10
    } srw_state_t;

    function automatic logic srw_at_last(input logic [CNT_W-1:0] cnt,
                                         input int                limit);
        return cnt == CNT_W'(limit - 1);
    endfunction

endpackage

// ===== srw_supervisor.sv
// Overview of operation
// - Supply below trip level asserts reset immediately.
// - Reset releases after 200 ms delay.
// - Supply dip re-asserts reset at once.
// - Brownout during delay restarts timer from zero.
// - Active-high reset is complement of low.
// - Missed kick drives watchdog fault low.
// - Kick edge clears counter; 1.56 s timeout.
// - Supply low forces watchdog fault low.
// - Watchdog fault follows supply without release delay.
// - Supply recovery returns fault high without delay.
// - Manual reset low holds reset, then delay.
// - Each manual bounce restarts the release delay.
// - Power-fail warning follows power-fail sense comparator.
// - Power-fail path independent of reset and watchdog.
// - Low-line warning follows its own comparator.
// - Lockout forces warnings and fault low.
// - Adjustable variant watches threshold sense input.
module srw_supervisor #(
    parameter int RELEASE_CYCLES_P = srw_pkg::RELEASE_CYCLES,
    parameter int RESTART_MIN_P    = srw_pkg::RESTART_MIN_CYCLES,
    parameter int WD_CYCLES_P      = srw_pkg::WD_TIMEOUT_CYCLES,
    parameter bit ADJ_THRESHOLD    = 1'b0
) (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic supply_ok_in,
    input  wire logic reset_sense_in,
    input  wire logic lowline_ok_in,
    input  wire logic lockout_ok_in,
    input  wire logic manual_reset_n,
    input  wire logic watchdog_kick_in,
    input  wire logic powerfail_sense_in,
    output logic      sys_reset_n,
    output logic      sys_reset,
    output logic      watchdog_fault_n,
    output logic      powerfail_warn_n,
    output logic      lowline_warn_n
);
    import srw_pkg::*;

    logic                senseRaw;
    logic                supplyLow;
    logic [NUM_SYNC-1:0] syncIn;
    logic [NUM_SYNC-1:0] syncA_r;
    logic [NUM_SYNC-1:0] syncB_r;
    logic                kickPrev_r;
    logic                kickEdge;
    logic                holdCause;
    logic                wdHold;
    srw_state_t          state_r;
    srw_state_t          state_nxt;
    logic [CNT_W-1:0]    relCnt_r;
    logic [CNT_W-1:0]    wdCnt_r;
    logic                wdTimedOut_r;
    logic                wdTimedOut_nxt;
    logic                sysReset_r;
    logic                sysResetN_r;
    logic                wdFaultN_r;
    logic                pfWarnN_r;
    logic                llWarnN_r;
    logic [CNT_W-1:0]    quietCnt_r;

    // Variant picks the comparator that gates reset
    assign senseRaw  = ADJ_THRESHOLD ? reset_sense_in : supply_ok_in;

    // Supply fault bypasses the synchroniser so reset is never late
    assign supplyLow = ~senseRaw;

    assign syncIn[SY_SUP]  = senseRaw;
    assign syncIn[SY_MR]   = manual_reset_n;
    assign syncIn[SY_KICK] = watchdog_kick_in;
    assign syncIn[SY_LL]   = lowline_ok_in;
    assign syncIn[SY_PF]   = powerfail_sense_in;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            syncA_r <= RST_SYNC;
            syncB_r <= RST_SYNC;
        end else begin
            syncA_r <= syncIn;
            syncB_r <= syncA_r;
        end
    end

    // Edge detector looks only at the second stage
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            kickPrev_r <= 1'b0;
        end else begin
            kickPrev_r <= syncB_r[SY_KICK];
        end
    end

    assign kickEdge = syncB_r[SY_KICK] ^ kickPrev_r;

    // Raw and synced supply both hold reset, so the delay starts clean
    assign holdCause = supplyLow | ~syncB_r[SY_SUP] | ~syncB_r[SY_MR];
    assign wdHold    = supplyLow | ~syncB_r[SY_SUP];

    always_comb begin
        state_nxt = state_r;
        if (holdCause) begin
            state_nxt = ST_HOLD;
        end else begin
            unique case (state_r)
                ST_HOLD: begin
                    state_nxt = ST_DELAY;
                end
                ST_DELAY: begin
                    if (srw_at_last(relCnt_r, RELEASE_CYCLES_P)) begin
                        state_nxt = ST_RUN;
                    end
                end
                ST_RUN: begin
                    state_nxt = ST_RUN;
                end
                default: begin
                    state_nxt = ST_HOLD;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_HOLD;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Any hold cause restarts the delay from zero
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            relCnt_r <= RST_CNT;
        end else if (holdCause || state_r != ST_DELAY) begin
            relCnt_r <= RST_CNT;
        end else begin
            relCnt_r <= relCnt_r + CNT_W'(1);
        end
    end

    // Both polarities from one decision keeps them exact complements
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sysResetN_r <= 1'b0;
            sysReset_r  <= 1'b1;
        end else begin
            sysResetN_r <= (state_nxt == ST_RUN);
            sysReset_r  <= (state_nxt != ST_RUN);
        end
    end

    // Timeout set wins over a kick in the same cycle
    always_comb begin
        wdTimedOut_nxt = wdTimedOut_r;
        if (wdHold) begin
            wdTimedOut_nxt = 1'b0;
        end else if (srw_at_last(wdCnt_r, WD_CYCLES_P) && !wdTimedOut_r) begin
            // Only arrival at terminal count sets, so a parked count cannot mask the next kick
            wdTimedOut_nxt = 1'b1;
        end else if (kickEdge) begin
            wdTimedOut_nxt = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wdTimedOut_r <= 1'b0;
        end else begin
            wdTimedOut_r <= wdTimedOut_nxt;
        end
    end

    // Counter parks at terminal count after a timeout
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wdCnt_r <= RST_CNT;
        end else if (wdHold || kickEdge) begin
            wdCnt_r <= RST_CNT;
        end else if (!srw_at_last(wdCnt_r, WD_CYCLES_P)) begin
            wdCnt_r <= wdCnt_r + CNT_W'(1);
        end
    end

    // Fault tracks the raw supply, no release delay involved
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wdFaultN_r <= 1'b0;
        end else begin
            wdFaultN_r <= lockout_ok_in & ~supplyLow & ~wdTimedOut_nxt;
        end
    end

    // Warning paths share nothing but the lockout
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pfWarnN_r <= 1'b0;
            llWarnN_r <= 1'b0;
        end else begin
            pfWarnN_r <= lockout_ok_in & syncB_r[SY_PF];
            llWarnN_r <= lockout_ok_in & syncB_r[SY_LL];
        end
    end

    assign sys_reset_n      = sysResetN_r;
    assign sys_reset        = sysReset_r;
    assign watchdog_fault_n = wdFaultN_r;
    assign powerfail_warn_n = pfWarnN_r;
    assign lowline_warn_n   = llWarnN_r;

    // Cycles since the last hold cause, for the restart check
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            quietCnt_r <= RST_CNT;
        end else if (holdCause) begin
            quietCnt_r <= RST_CNT;
        end else if (quietCnt_r != {CNT_W{1'b1}}) begin
            quietCnt_r <= quietCnt_r + CNT_W'(1);
        end
    end

    AST_SUPPLY_LOW_RESET: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        supplyLow |=> !sys_reset_n && sys_reset)
        else $error("reset not asserted on low supply");

    AST_RELEASE_DELAY: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        $rose(sys_reset_n) |->
            $past(state_r) == ST_DELAY &&
            $past(relCnt_r) == CNT_W'(RELEASE_CYCLES_P - 1))
        else $error("reset released without full delay");

    AST_DIP_PULSE: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        sys_reset_n && supplyLow |=> $fell(sys_reset_n))
        else $error("supply dip gave no reset pulse");

    AST_RESTART_MIN: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        $rose(sys_reset_n) |-> quietCnt_r >= CNT_W'(RESTART_MIN_P))
        else $error("reset released too soon after brownout");

    AST_COMPLEMENT: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        sys_reset == !sys_reset_n)
        else $error("reset outputs not complementary");

    AST_WD_TIMEOUT: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        srw_at_last(wdCnt_r, WD_CYCLES_P) && !wdHold && !(wdTimedOut_r && kickEdge)
            |=> !watchdog_fault_n)
        else $error("watchdog timeout not reported");

    AST_KICK_CLEARS: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        kickEdge |=> wdCnt_r == RST_CNT)
        else $error("kick edge did not clear counter");

    AST_WD_WITH_RESET: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        supplyLow |=> !watchdog_fault_n && !sys_reset_n)
        else $error("fault and reset not low together");

    AST_WD_RECOVER: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !supplyLow && lockout_ok_in && !wdTimedOut_nxt
            |=> watchdog_fault_n)
        else $error("fault output did not recover");

    AST_MANUAL_HOLD: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !syncB_r[SY_MR] |=> !sys_reset_n && relCnt_r == RST_CNT)
        else $error("manual reset did not hold reset");

    AST_PF_FOLLOW: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        lockout_ok_in |=> powerfail_warn_n == $past(syncB_r[SY_PF]))
        else $error("power-fail warning mismatch");

    AST_LOCKOUT: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !lockout_ok_in |=>
            !lowline_warn_n && !powerfail_warn_n && !watchdog_fault_n)
        else $error("lockout did not force outputs low");

    AST_WD_HELD: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        wdHold |=> wdCnt_r == RST_CNT && !wdTimedOut_r)
        else $error("watchdog counter not held cleared");

    AST_WD_NO_DELAY: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !supplyLow && $past(supplyLow) && lockout_ok_in
            |=> watchdog_fault_n && !sys_reset_n)
        else $error("fault output delayed after supply recovery");

    AST_KICK_RECOVER: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        wdTimedOut_r && kickEdge && !wdHold && lockout_ok_in
            |=> watchdog_fault_n)
        else $error("kick edge did not end the timeout");

    AST_WD_BOUND: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        wdCnt_r <= CNT_W'(WD_CYCLES_P - 1))
        else $error("watchdog counter passed terminal count");

    AST_DELAY_BOUND: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        state_r == ST_DELAY |-> relCnt_r < CNT_W'(RELEASE_CYCLES_P))
        else $error("release counter passed terminal count");

    AST_BOUNCE_RESTART: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        $rose(syncB_r[SY_MR]) |-> relCnt_r == RST_CNT && !sys_reset_n)
        else $error("manual release did not start a fresh delay");

    AST_SENSE_SELECT: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (ADJ_THRESHOLD ? !reset_sense_in : !supply_ok_in)
            |=> !sys_reset_n && !watchdog_fault_n)
        else $error("selected comparator did not assert reset");

    AST_SYNC_STAGES: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        $past(rst_n, 2) |-> syncB_r == $past(syncIn, 2))
        else $error("synchroniser is not two stages deep");

    AST_PF_INDEPENDENT: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        lockout_ok_in && syncB_r[SY_PF] && (!sys_reset_n || !watchdog_fault_n)
            |=> powerfail_warn_n)
        else $error("power-fail warning gated by reset or fault");

    AST_LOWLINE_FOLLOW: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        lockout_ok_in |=> lowline_warn_n == $past(syncB_r[SY_LL]))
        else $error("low-line warning mismatch");

endmodule

// ===== srw_host_model.sv
module srw_host_model (
    input  wire logic       ref_clk,
    input  wire logic       kickEn,
    input  wire logic       routeFault,
    input  wire logic [7:0] kickGap,
    input  wire logic       mrDriveN,
    input  wire logic       watchdog_fault_n,
    output logic            watchdog_kick_in,
    output logic            manual_reset_n
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] gapCnt = 8'h00;
    initial watchdog_kick_in = 1'b0;
    // Host toggles its kick line every kickGap+1 cycles while alive
    always @(posedge ref_clk) begin
        if (kickEn && gapCnt >= kickGap) begin
            watchdog_kick_in <= #1 ~watchdog_kick_in;
            gapCnt <= 8'h00;
        end else begin
            gapCnt <= gapCnt + 8'h01;
        end
    end
    // Fault wired into manual reset, so a timeout resets the host
    assign manual_reset_n = routeFault ? (mrDriveN & watchdog_fault_n) : mrDriveN;
endmodule

// ===== tb.sv
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int REL = 20;
    localparam int WD  = 50;
    logic       ref_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       supplyOk = 1'b0;
    logic       lowlineOk = 1'b0;
    logic       lockoutOk = 1'b0;
    logic       pfSense = 1'b0;
    logic       mrDriveN = 1'b1;
    logic       kickEn = 1'b0;
    logic       routeFault = 1'b0;
    logic [7:0] kickGap = 8'h0A;
    logic       kick, mrN, sysRstN, sysRst, wdFaultN, pfWarnN, llWarnN;
    int         miscompares = 0;
    int         testsRun = 0;
    int         n, i, k;

    always #5 ref_clk = ~ref_clk;

    srw_supervisor #(.RELEASE_CYCLES_P(REL), .RESTART_MIN_P(14), .WD_CYCLES_P(WD)) srw_supervisor_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .supply_ok_in(supplyOk), .reset_sense_in(supplyOk),
        .lowline_ok_in(lowlineOk), .lockout_ok_in(lockoutOk), .manual_reset_n(mrN),
        .watchdog_kick_in(kick), .powerfail_sense_in(pfSense), .sys_reset_n(sysRstN),
        .sys_reset(sysRst), .watchdog_fault_n(wdFaultN), .powerfail_warn_n(pfWarnN),
        .lowline_warn_n(llWarnN));

    srw_host_model srw_host_model_inst (
        .ref_clk(ref_clk), .kickEn(kickEn), .routeFault(routeFault), .kickGap(kickGap),
        .mrDriveN(mrDriveN), .watchdog_fault_n(wdFaultN), .watchdog_kick_in(kick),
        .manual_reset_n(mrN));

    // Drive and sample 1 ns after the edge, so flop updates have landed
    task automatic cyc(input int c = 1);
        repeat (c) @(posedge ref_clk);
        #1;
    endtask

    task automatic check(input logic seen, input logic exp, input string what);
        testsRun++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", testsRun, miscompares);
        if (miscompares == 0 && testsRun > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Cycles until reset (sel 0) or fault (sel 1) reaches lvl
    task automatic waitLvl(input int sel, input logic lvl, output int cnt);
        cnt = 0;
        while ((sel ? wdFaultN : sysRstN) !== lvl) begin
            check(sysRst, ~sysRstN, "reset outputs not complementary");
            cnt++;
            if (cnt > 300) begin
                miscompares++;
                report_and_stop();
            end
            cyc();
        end
    endtask

    task automatic endTest(input string name);
        $display("test %s done, checks %0d, mismatches %0d", name, testsRun, miscompares);
    endtask

    function automatic logic expWarn(input logic lock, input logic cmp);
        return lock & cmp;
    endfunction

    function automatic logic inRange(input int v, input int lo, input int hi);
        return v >= lo && v <= hi;
    endfunction

    initial begin
        void'($urandom(8));
        cyc(4);
        rst_n = 1'b1;
        {supplyOk, lowlineOk, lockoutOk, pfSense, kickEn} = 5'h1F;
        waitLvl(0, 1'b1, n);
        check(inRange(n, REL, REL + 8), 1'b1, "power-up release delay");
        endTest("powerup");
        // Short dip in run, then a brownout in the middle of the delay
        supplyOk = 1'b0;
        cyc(2);
        check(sysRstN, 1'b0, "dip did not assert reset");
        check(wdFaultN, 1'b0, "fault high during dip");
        supplyOk = 1'b1;
        cyc(REL / 2);
        supplyOk = 1'b0;
        cyc(2);
        supplyOk = 1'b1;
        cyc(2);
        check(wdFaultN, 1'b1, "fault not back high at once");
        check(sysRstN, 1'b0, "reset released early");
        waitLvl(0, 1'b1, n);
        check(inRange(n, REL - 2, REL + 8), 1'b1, "delay not restarted");
        endTest("brownout");
        // Bouncing switch: every low restarts the delay
        k = $urandom_range(5, 1);
        for (i = 0; i < k; i++) begin
            mrDriveN = 1'b0;
            cyc($urandom_range(8, 4));
            check(sysRstN, 1'b0, "manual low without reset");
            mrDriveN = 1'b1;
            if (i < k - 1) cyc($urandom_range(REL / 2, 1));
        end
        waitLvl(0, 1'b1, n);
        check(inRange(n, REL, REL + 8), 1'b1, "manual release delay");
        endTest("manual");
        // Regular kicks, then silence, then recovery, then a routed timeout and a second recovery
        kickGap = 8'($urandom_range(40, 5));
        cyc(3 * WD);
        check(wdFaultN, 1'b1, "fault despite kicks");
        kickEn = 1'b0;
        waitLvl(1, 1'b0, n);
        check(inRange(n, WD - int'(kickGap) - 2, WD + 6), 1'b1, "timeout time");
        kickEn = 1'b1;
        waitLvl(1, 1'b1, n);
        check(inRange(n, 0, int'(kickGap) + 8), 1'b1, "kick did not clear");
        check(sysRstN, 1'b1, "timeout caused reset unrouted");
        routeFault = 1'b1;
        kickEn = 1'b0;
        waitLvl(0, 1'b0, n);
        check(inRange(n, 0, WD + 12), 1'b1, "routed timeout no reset");
        kickEn = 1'b1;
        waitLvl(0, 1'b1, n);
        routeFault = 1'b0;
        endTest("watchdog");
        // Long supply loss holds the counter clear
        kickEn = 1'b0;
        supplyOk = 1'b0;
        cyc(WD + 10);
        supplyOk = 1'b1;
        cyc(WD - 10);
        check(wdFaultN, 1'b1, "counter ran while supply low");
        waitLvl(1, 1'b0, n);
        check(inRange(n, 0, 20), 1'b1, "timeout after recovery");
        // Host has been idle long enough that it toggles on the very next edge
        kickEn = 1'b1;
        waitLvl(1, 1'b1, n);
        check(inRange(n, 1, 5), 1'b1, "first kick did not end timeout");
        waitLvl(0, 1'b1, n);
        endTest("lowsupply");
        // Warnings and lockout under random comparators and manual resets
        for (i = 0; i < 24; i++) begin
            lowlineOk = 1'($urandom);
            pfSense = 1'($urandom);
            lockoutOk = ($urandom_range(3, 0) != 0);
            mrDriveN = 1'($urandom);
            cyc(4);
            check(pfWarnN, expWarn(lockoutOk, pfSense), "power-fail warning");
            check(llWarnN, expWarn(lockoutOk, lowlineOk), "low-line warning");
            check(wdFaultN, lockoutOk, "fault under lockout");
        end
        endTest("warnings");
        report_and_stop();
    end
endmodule
